// File: hw/cog_clamp_offset_gain.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Clamp source bit selects external clamp pin
// - Polarity field sets external clamp active level
// - Wait placement pixels after sync trailing edge
// - Hold clamp for duration pixel periods
// - Per-channel midscale or ground clamp select
// - Seven-bit gain per channel, 0 highest
// - Offset pair: manual offset or target code
// - Manual offset: seven bits, two's complement, -64 to +63
// - Auto mode steers offset toward target code
// - Target code is nine-bit two's complement
// - Sixteen-cycle update right after clamp ends
// - Hold bit picks continuous or one-time
// - Rate field sets interval in line syncs
module cog_clamp_offset_gain
  import cog_pkg::*;
#(
  parameter int DATA_W = 8  // Converter sample width
)
(
  // Clock and reset
  input  wire logic              CLK,
  input  wire logic              NRST,
  // Register access from the serial port
  input  wire logic              REG_WE,
  input  wire logic              REG_RE,
  input  wire logic [7:0]        REG_ADDR,
  input  wire logic [7:0]        REG_WDATA,
  output logic      [7:0]        REG_RDATA,
  // Source timing
  input  wire logic              HSYNC,
  input  wire logic              CLAMP_PIN,
  // Converter samples
  input  wire logic [DATA_W-1:0] ADC_RED,
  input  wire logic [DATA_W-1:0] ADC_GREEN,
  input  wire logic [DATA_W-1:0] ADC_BLUE,
  // Analog front-end controls
  output logic                   CLAMP_OUT,
  output logic      [2:0]        CLAMP_MID,
  output logic      [6:0]        GAIN_RED,
  output logic      [6:0]        GAIN_GREEN,
  output logic      [6:0]        GAIN_BLUE,
  output logic      [8:0]        OFFSET_RED,
  output logic      [8:0]        OFFSET_GREEN,
  output logic      [8:0]        OFFSET_BLUE,
  output logic                   CAL_BUSY
);

  // ==========================================================
  // Parameter check
  // ==========================================================
  // The averaged sample must fit beside the 9-bit target
  if (DATA_W < 1 || DATA_W > 9)
  begin : g_bad_width
    $error("cog_clamp_offset_gain: DATA_W must be 1 to 9");
  end

  localparam int SUM_W = DATA_W + 4;  // Sum of sixteen samples

  // ==========================================================
  // State record
  // ==========================================================
  typedef struct packed {
    cog_state_e                  st;        // Internal clamp generator
    logic [7:0]                  cnt;       // Placement or duration count
    logic                        hs_d;      // Previous sync level
    logic                        clamp_d;   // Registered clamp
    logic                        cal_on;    // Update window open
    logic [4:0]                  cal_cnt;   // Samples taken
    logic                        due;       // Update allowed this window
    logic                        once_done; // One-time update spent
    logic [7:0]                  line_cnt;  // Line syncs since last due
    logic [NUM_REGS-1:0][7:0]    regs;      // Register storage
    logic [2:0][SUM_W-1:0]       sum;       // Per-channel sample sums
    logic [2:0][8:0]             acc;       // Applied offsets
    logic [7:0]                  rdata;     // Read data
  } cog_state_s;

  cog_state_s s_r;    // Current state
  cog_state_s s_nxt;  // Next state

  // ==========================================================
  // Helpers
  // ==========================================================
  // Address decode; unmapped offsets report no hit
  function automatic logic [4:0] reg_index(input logic [7:0] addr);
    logic [4:0] r;
    r = {1'b0, IDX_RED_GAIN};
    case (addr)
      OFS_RED_GAIN:          r = {1'b1, IDX_RED_GAIN};
      OFS_GREEN_GAIN:        r = {1'b1, IDX_GRN_GAIN};
      OFS_BLUE_GAIN:         r = {1'b1, IDX_BLU_GAIN};
      OFS_RED_OFFSET_HIGH:   r = {1'b1, IDX_RED_OFSH};
      OFS_RED_OFFSET_LOW:    r = {1'b1, IDX_RED_OFSL};
      OFS_GREEN_OFFSET_HIGH: r = {1'b1, IDX_GRN_OFSH};
      OFS_GREEN_OFFSET_LOW:  r = {1'b1, IDX_GRN_OFSL};
      OFS_BLUE_OFFSET_HIGH:  r = {1'b1, IDX_BLU_OFSH};
      OFS_BLUE_OFFSET_LOW:   r = {1'b1, IDX_BLU_OFSL};
      OFS_CLAMP_CONTROL:     r = {1'b1, IDX_CLAMP};
      OFS_CLAMP_PLACEMENT:   r = {1'b1, IDX_PLACE};
      OFS_CLAMP_DURATION:    r = {1'b1, IDX_DUR};
      OFS_AUTO_OFFSET_CTRL:  r = {1'b1, IDX_AUTO};
      OFS_CALIBRATION_HOLD:  r = {1'b1, IDX_HOLD};
      default:               r = {1'b0, IDX_RED_GAIN};
    endcase
    return r;
  endfunction : reg_index

  // ==========================================================
  // Decoded controls
  // ==========================================================
  logic [4:0]         wr_hit;     // Write decode
  logic [4:0]         rd_hit;     // Read decode
  logic               ext_src;    // External clamp selected
  logic               ext_high;   // External clamp active high
  logic               auto_en;    // Auto-offset enabled
  logic               hold_once;  // One-time auto-offset
  logic [1:0]         rate;       // Update rate code
  logic [7:0]         interval;   // Line syncs per update, minus one
  logic               hs_trail;   // Trailing edge of line sync
  logic               clamp_now;  // Clamp level this cycle
  logic [2:0][8:0]    target;     // Per-channel target codes
  logic [2:0][8:0]    manual;     // Per-channel manual offsets
  logic [2:0][DATA_W-1:0] sample; // Per-channel samples

  assign wr_hit    = reg_index(REG_ADDR);
  assign rd_hit    = wr_hit;
  assign ext_src   = s_r.regs[IDX_CLAMP][BIT_CLAMP_SRC];
  // polarity field, low bit decides the level
  assign ext_high  = s_r.regs[IDX_CLAMP][BIT_CLAMP_POL];
  // mode bit reinterprets the offset pairs
  assign auto_en   = s_r.regs[IDX_AUTO][BIT_AUTO_EN];
  assign hold_once = s_r.regs[IDX_HOLD][BIT_AUTO_HOLD];
  assign rate      = s_r.regs[IDX_AUTO][BIT_RATE_LO+1 -: 2];
  // trailing edge found in the pixel clock domain
  assign hs_trail  = s_r.hs_d & ~HSYNC;
  assign sample    = {ADC_RED, ADC_GREEN, ADC_BLUE};

  // interval chosen by the rate field
  always_comb
  begin
    case (rate)
      2'b00:   interval = RATE_1;
      2'b01:   interval = RATE_16;
      2'b10:   interval = RATE_64;
      default: interval = RATE_256;
    endcase
  end

  // Clamp level from the pin or the internal generator
  always_comb
  begin
    // external pin replaces the internal generator
    if (ext_src)
      // active level from the polarity field
      clamp_now = (CLAMP_PIN == ext_high);
    else
      clamp_now = (s_r.st == COG_CLAMP);
  end

  // Target codes and manual offsets per channel
  always_comb
  begin
    for (int c = 0; c < 3; c++)
    begin
      // nine-bit two's complement target, high byte first
      target[c] = {s_r.regs[IDX_RED_OFSH + 4'(2*(2-c))],
                   s_r.regs[IDX_RED_OFSL + 4'(2*(2-c))][BIT_TARGET_LSB]};
      // seven low bits, sign-extended, one step per code
      manual[c] = {{2{s_r.regs[IDX_RED_OFSH + 4'(2*(2-c))][6]}},
                   s_r.regs[IDX_RED_OFSH + 4'(2*(2-c))][6:0]};
    end
  end

  // ==========================================================
  // Next-state logic
  // ==========================================================
  always_comb
  begin
    logic [SUM_W-1:0] tot;   // Sum including the last sample
    logic [9:0]       avg;   // Average as signed ten-bit value
    logic [9:0]       tgt;   // Target as signed ten-bit value
    tot   = '0;
    avg   = '0;
    tgt   = '0;
    s_nxt = s_r;

    // Register writes
    if (REG_WE && wr_hit[4])
      s_nxt.regs[wr_hit[3:0]] = REG_WDATA;

    // Registered read; unmapped offsets read as zero
    if (REG_RE)
      s_nxt.rdata = rd_hit[4] ? s_r.regs[rd_hit[3:0]] : RST_ZERO;

    s_nxt.hs_d    = HSYNC;
    s_nxt.clamp_d = clamp_now;

    // internal generator, restarted by every trailing edge while the pin is not selected
    if (ext_src)
    begin
      s_nxt.st  = COG_IDLE;
      s_nxt.cnt = RST_ZERO;
    end
    else if (hs_trail)
    begin
      // Zero placement clamps on the very next cycle
      if (s_r.regs[IDX_PLACE] != RST_ZERO)
      begin
        s_nxt.st  = COG_PLACE;
        s_nxt.cnt = s_r.regs[IDX_PLACE] - 8'h01;
      end
      else if (s_r.regs[IDX_DUR] != RST_ZERO)
      begin
        s_nxt.st  = COG_CLAMP;
        s_nxt.cnt = s_r.regs[IDX_DUR] - 8'h01;
      end
      else
        s_nxt.st  = COG_IDLE;
    end
    else
    begin
      case (s_r.st)
        // Waiting out the placement count
        COG_PLACE:
        begin
          if (s_r.cnt != RST_ZERO)
            s_nxt.cnt = s_r.cnt - 8'h01;
          // zero duration means no clamp this line
          else if (s_r.regs[IDX_DUR] != RST_ZERO)
          begin
            s_nxt.st  = COG_CLAMP;
            s_nxt.cnt = s_r.regs[IDX_DUR] - 8'h01;
          end
          else
            s_nxt.st  = COG_IDLE;
        end
        // clamp stands for the duration count
        COG_CLAMP:
        begin
          if (s_r.cnt != RST_ZERO)
            s_nxt.cnt = s_r.cnt - 8'h01;
          else
            s_nxt.st  = COG_IDLE;
        end
        COG_IDLE:
          s_nxt.st = COG_IDLE;
        default:
          s_nxt.st = COG_IDLE;
      endcase
    end

    // count line syncs toward the next allowed update
    if (hs_trail)
    begin
      if (s_r.line_cnt >= interval)
      begin
        s_nxt.line_cnt = RST_ZERO;
        s_nxt.due      = 1'b1;
      end
      else
        s_nxt.line_cnt = s_r.line_cnt + 8'h01;
    end

    // window opens on the cycle after clamp falls
    if (auto_en && s_r.clamp_d && !clamp_now && !s_r.cal_on)
    begin
      s_nxt.cal_on  = 1'b1;
      s_nxt.cal_cnt = '0;
      s_nxt.sum     = '0;
    end
    else if (s_r.cal_on)
    begin
      for (int c = 0; c < 3; c++)
        s_nxt.sum[c] = s_r.sum[c] + SUM_W'(sample[c]);
      s_nxt.cal_cnt = s_r.cal_cnt + 5'h01;
      // Last of the sixteen samples
      if (s_r.cal_cnt == CAL_CYCLES - 5'h01)
      begin
        s_nxt.cal_on = 1'b0;
        // one-time mode applies a single update only
        if (s_r.due && !(hold_once && s_r.once_done))
        begin
          // Clearing due here; a new line sync in this cycle wins
          s_nxt.due       = hs_trail && (s_r.line_cnt >= interval);
          s_nxt.once_done = 1'b1;
          for (int c = 0; c < 3; c++)
          begin
            tot = s_r.sum[c] + SUM_W'(sample[c]);
            avg = 10'(tot[SUM_W-1:4]);
            tgt = {target[c][8], target[c]};
            // step the offset one code toward the target
            if ($signed(avg) < $signed(tgt) && s_r.acc[c] != 9'h0FF)
              s_nxt.acc[c] = s_r.acc[c] + 9'h001;
            else if ($signed(avg) > $signed(tgt) && s_r.acc[c] != 9'h100)
              s_nxt.acc[c] = s_r.acc[c] - 9'h001;
          end
        end
      end
    end

    // manual mode applies the register value directly
    if (!auto_en)
    begin
      s_nxt.acc       = manual;
      s_nxt.cal_on    = 1'b0;
      s_nxt.once_done = 1'b0;
    end
  end

  // ==========================================================
  // State register
  // ==========================================================
  // Synchronous reset; recommended clamp timing after reset
  always_ff @(posedge CLK)
  begin
    if (!NRST)
    begin
      s_r                <= '0;
      s_r.st             <= COG_IDLE;
      s_r.regs[IDX_PLACE] <= RST_PLACEMENT;
      s_r.regs[IDX_DUR]   <= RST_DURATION;
    end
    else
      s_r <= s_nxt;
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  assign REG_RDATA    = s_r.rdata;
  assign CLAMP_OUT    = s_r.clamp_d;
  // independent midscale select for each converter
  assign CLAMP_MID    = {s_r.regs[IDX_CLAMP][BIT_SEL_RED],
                         s_r.regs[IDX_CLAMP][BIT_SEL_GREEN],
                         s_r.regs[IDX_CLAMP][BIT_SEL_BLUE]};
  // seven-bit gain, 0 is the highest gain
  assign GAIN_RED     = s_r.regs[IDX_RED_GAIN][6:0];
  assign GAIN_GREEN   = s_r.regs[IDX_GRN_GAIN][6:0];
  assign GAIN_BLUE    = s_r.regs[IDX_BLU_GAIN][6:0];
  assign OFFSET_RED   = s_r.acc[2];
  assign OFFSET_GREEN = s_r.acc[1];
  assign OFFSET_BLUE  = s_r.acc[0];
  assign CAL_BUSY     = s_r.cal_on;

endmodule : cog_clamp_offset_gain

// File: include/cog_pkg.sv
// ============================================================
// Clamp, offset and gain control constants
// ============================================================
package cog_pkg;

  // ==========================================================
  // Register offsets
  // ==========================================================
  localparam logic [7:0] OFS_RED_GAIN          = 8'h05;
  localparam logic [7:0] OFS_GREEN_GAIN        = 8'h07;
  localparam logic [7:0] OFS_BLUE_GAIN         = 8'h09;
  localparam logic [7:0] OFS_RED_OFFSET_HIGH   = 8'h0B;
  localparam logic [7:0] OFS_RED_OFFSET_LOW    = 8'h0C;
  localparam logic [7:0] OFS_GREEN_OFFSET_HIGH = 8'h0D;
  localparam logic [7:0] OFS_GREEN_OFFSET_LOW  = 8'h0E;
  localparam logic [7:0] OFS_BLUE_OFFSET_HIGH  = 8'h0F;
  localparam logic [7:0] OFS_BLUE_OFFSET_LOW   = 8'h10;
  localparam logic [7:0] OFS_CLAMP_CONTROL     = 8'h18;
  localparam logic [7:0] OFS_CLAMP_PLACEMENT   = 8'h19;
  localparam logic [7:0] OFS_CLAMP_DURATION    = 8'h1A;
  localparam logic [7:0] OFS_AUTO_OFFSET_CTRL  = 8'h1B;
  localparam logic [7:0] OFS_CALIBRATION_HOLD  = 8'h2C;

  // ==========================================================
  // Storage indices (one byte each)
  // ==========================================================
  localparam int          NUM_REGS     = 14;
  localparam logic [3:0]  IDX_RED_GAIN = 4'h0;
  localparam logic [3:0]  IDX_GRN_GAIN = 4'h1;
  localparam logic [3:0]  IDX_BLU_GAIN = 4'h2;
  localparam logic [3:0]  IDX_RED_OFSH = 4'h3;
  localparam logic [3:0]  IDX_RED_OFSL = 4'h4;
  localparam logic [3:0]  IDX_GRN_OFSH = 4'h5;
  localparam logic [3:0]  IDX_GRN_OFSL = 4'h6;
  localparam logic [3:0]  IDX_BLU_OFSH = 4'h7;
  localparam logic [3:0]  IDX_BLU_OFSL = 4'h8;
  localparam logic [3:0]  IDX_CLAMP    = 4'h9;
  localparam logic [3:0]  IDX_PLACE    = 4'hA;
  localparam logic [3:0]  IDX_DUR      = 4'hB;
  localparam logic [3:0]  IDX_AUTO     = 4'hC;
  localparam logic [3:0]  IDX_HOLD     = 4'hD;

  // ==========================================================
  // Field positions
  // ==========================================================
  localparam int BIT_CLAMP_SRC    = 4;  // 1: external clamp pin
  localparam int BIT_CLAMP_POL    = 6;  // Low bit of polarity field
  localparam int BIT_SEL_RED      = 3;  // 1: midscale clamp
  localparam int BIT_SEL_GREEN    = 2;
  localparam int BIT_SEL_BLUE     = 1;
  localparam int BIT_AUTO_EN      = 5;
  localparam int BIT_RATE_LO      = 3;  // Update rate field [4:3]
  localparam int BIT_AUTO_HOLD    = 4;
  localparam int BIT_TARGET_LSB   = 7;  // Low register carries bit 0

  // ==========================================================
  // Reset values and timing
  // ==========================================================
  localparam logic [7:0] RST_ZERO      = 8'h00;
  localparam logic [7:0] RST_PLACEMENT = 8'h04;
  localparam logic [7:0] RST_DURATION  = 8'h28;
  localparam logic [4:0] CAL_CYCLES    = 5'h10;  // Samples per update
  // Update interval in line syncs, per rate code 0..3
  localparam logic [7:0] RATE_1        = 8'h00;  // Interval minus one
  localparam logic [7:0] RATE_16       = 8'h0F;
  localparam logic [7:0] RATE_64       = 8'h3F;
  localparam logic [7:0] RATE_256      = 8'hFF;

  // Clamp generator states, Gray from idle through placement to clamp
  typedef enum logic [1:0] {
    COG_IDLE  = 2'b00,
    COG_PLACE = 2'b01,
    COG_CLAMP = 2'b11,
    COG_SPARE = 2'b10
  } cog_state_e;

endpackage : cog_pkg

// File: verification/cog_clamp_offset_gain_sva.sv
`timescale 1ns/1ps
// ====================
// Port checker
module cog_clamp_offset_gain_sva
  import cog_pkg::*;
#(
  parameter int DATA_W = 8  // Converter sample width
)
(
  // Clock and reset
  input wire logic              CLK,
  input wire logic              NRST,
  // Register access
  input wire logic              REG_WE,
  input wire logic              REG_RE,
  input wire logic [7:0]        REG_ADDR,
  input wire logic [7:0]        REG_WDATA,
  input wire logic [7:0]        REG_RDATA,
  // Source timing
  input wire logic              HSYNC,
  input wire logic              CLAMP_PIN,
  // Samples
  input wire logic [DATA_W-1:0] ADC_RED,
  input wire logic [DATA_W-1:0] ADC_GREEN,
  input wire logic [DATA_W-1:0] ADC_BLUE,
  // Front-end controls
  input wire logic              CLAMP_OUT,
  input wire logic [2:0]        CLAMP_MID,
  input wire logic [6:0]        GAIN_RED,
  input wire logic [6:0]        GAIN_GREEN,
  input wire logic [6:0]        GAIN_BLUE,
  input wire logic [8:0]        OFFSET_RED,
  input wire logic [8:0]        OFFSET_GREEN,
  input wire logic [8:0]        OFFSET_BLUE,
  input wire logic              CAL_BUSY
);
  // ====================
  // Shadow bytes and run counters
  logic [7:0] ctl_r, place_r, dur_r, auto_r;  // Copies seen on the bus
  logic       hs_r;                           // Sync, one cycle late
  logic [8:0] since_r;                        // Cycles since trailing edge
  logic [8:0] hi_r;                           // Clamp run length so far
  logic [4:0] busy_r;                         // Sampling run length so far

  // Shadows only follow writes, so a missed write shows as a mismatch
  always_ff @(posedge CLK)
  begin
    hs_r   <= HSYNC;
    hi_r   <= CLAMP_OUT ? hi_r + 9'h001 : 9'h000;
    busy_r <= CAL_BUSY ? busy_r + 5'h01 : 5'h00;
    if (!NRST)
    begin
      ctl_r   <= 8'h00;
      place_r <= 8'h04;
      dur_r   <= 8'h28;
      auto_r  <= 8'h00;
      since_r <= 9'h1FF;
    end
    else
    begin
      if (REG_WE && REG_ADDR == OFS_CLAMP_CONTROL) ctl_r <= REG_WDATA;
      if (REG_WE && REG_ADDR == OFS_CLAMP_PLACEMENT) place_r <= REG_WDATA;
      if (REG_WE && REG_ADDR == OFS_CLAMP_DURATION) dur_r <= REG_WDATA;
      if (REG_WE && REG_ADDR == OFS_AUTO_OFFSET_CTRL) auto_r <= REG_WDATA;
      // Saturate so a stale count never wraps into range
      if (hs_r && !HSYNC) since_r <= 9'h000;
      else if (since_r != 9'h1FF) since_r <= since_r + 9'h001;
    end
  end

  // ====================
  // Assertions
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);

  // Sampling window opening
  sequence s_cal_start;
    $rose(CAL_BUSY);
  endsequence

  a_gain_write: assert property (REG_WE && REG_ADDR == OFS_RED_GAIN |-> ##2
    GAIN_RED == $past(REG_WDATA[6:0], 2)) else $error("red gain not applied");
  a_mid_select: assert property (REG_WE && REG_ADDR == OFS_CLAMP_CONTROL |-> ##2
    CLAMP_MID == $past(REG_WDATA[3:1], 2)) else $error("clamp level select wrong");
  a_manual_offset: assert property (REG_WE && REG_ADDR == OFS_RED_OFFSET_HIGH
    && !auto_r[5] |-> ##2 OFFSET_RED == {{2{$past(REG_WDATA[6], 2)}},
    $past(REG_WDATA[6:0], 2)}) else $error("manual offset wrong");
  a_ext_follow: assert property (ctl_r[4] && $past(ctl_r[4])
    && $past(ctl_r[6]) == ctl_r[6] |-> CLAMP_OUT == ($past(CLAMP_PIN) == ctl_r[6]))
    else $error("external clamp not followed");
  a_place_rise: assert property ($rose(CLAMP_OUT) && !ctl_r[4] && !$past(ctl_r[4])
    |-> since_r == {1'b0, place_r} + 9'h001 || since_r == {1'b0, place_r} + 9'h002)
    else $error("clamp starts at wrong place");
  a_dur_len: assert property ($fell(CLAMP_OUT) && !ctl_r[4] && !$past(ctl_r[4])
    && since_r != 9'h1FF |-> hi_r == {1'b0, dur_r}) else $error("clamp length wrong");
  a_cal_start: assert property (s_cal_start |-> $fell(CLAMP_OUT))
    else $error("sampling not at clamp end");
  a_cal_len: assert property ($fell(CAL_BUSY) && auto_r[5] && $past(auto_r[5])
    |-> busy_r == 5'h10) else $error("sampling window length wrong");
  a_offset_hold: assert property (auto_r[5] && $past(auto_r[5], 2)
    && !$fell(CAL_BUSY) |-> $stable(OFFSET_RED)) else $error("offset moved off window");
endmodule : cog_clamp_offset_gain_sva

bind cog_clamp_offset_gain cog_clamp_offset_gain_sva #(.DATA_W(DATA_W)) cog_sva_i (
  .CLK(CLK), .NRST(NRST), .REG_WE(REG_WE), .REG_RE(REG_RE), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .HSYNC(HSYNC), .CLAMP_PIN(CLAMP_PIN),
  .ADC_RED(ADC_RED), .ADC_GREEN(ADC_GREEN), .ADC_BLUE(ADC_BLUE), .CLAMP_OUT(CLAMP_OUT),
  .CLAMP_MID(CLAMP_MID), .GAIN_RED(GAIN_RED), .GAIN_GREEN(GAIN_GREEN),
  .GAIN_BLUE(GAIN_BLUE), .OFFSET_RED(OFFSET_RED), .OFFSET_GREEN(OFFSET_GREEN),
  .OFFSET_BLUE(OFFSET_BLUE), .CAL_BUSY(CAL_BUSY));

// File: verification/cog_clamp_offset_gain_test.sv
`timescale 1ns/1ps
// ====================
// Self-checking bench
module cog_clamp_offset_gain_test;
  import cog_pkg::*;
  logic       clk, nrst, reg_we, reg_re, hsync, clamp_pin, clamp_out, cal_busy, pol;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, level, adc_red, adc_green, adc_blue;
  logic [2:0] clamp_mid;
  logic [6:0] gain_red, gain_green, gain_blue;
  logic [8:0] offset_red, offset_green, offset_blue;
  int         miscompares = 0, comparisons = 0, cycles = 0;
  // Rows: address, reset value, write data, read-back
  logic [31:0] rows [15] = '{32'h0500FFFF, 32'h07003535, 32'h09004040, 32'h0B004141,
    32'h0C008080, 32'h0D003F3F, 32'h0E000000, 32'h0F000000, 32'h10008080, 32'h18000A0A,
    32'h19040404, 32'h1A282828, 32'h1B000000, 32'h2C000000, 32'h0600AA00};
  logic [15:0] pd [4] = '{16'h0428, 16'h0001, 16'h0A3C, 16'h0400};  // Placement, duration
  logic [15:0] tg [6] = '{16'h0B02, 16'h0C00, 16'h0DFF, 16'h0E00, 16'h0F14, 16'h1000};
  int          ivl [4] = '{1, 16, 64, 256};  // Lines per update, per rate code

  cog_clamp_offset_gain #(.DATA_W(8)) cog_clamp_offset_gain_i (.CLK(clk), .NRST(nrst),
    .REG_WE(reg_we), .REG_RE(reg_re), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_RDATA(reg_rdata), .HSYNC(hsync), .CLAMP_PIN(clamp_pin), .ADC_RED(adc_red),
    .ADC_GREEN(adc_green), .ADC_BLUE(adc_blue), .CLAMP_OUT(clamp_out),
    .CLAMP_MID(clamp_mid), .GAIN_RED(gain_red), .GAIN_GREEN(gain_green),
    .GAIN_BLUE(gain_blue), .OFFSET_RED(offset_red), .OFFSET_GREEN(offset_green),
    .OFFSET_BLUE(offset_blue), .CAL_BUSY(cal_busy));
  cog_source_model cog_source_model_i (.clk(clk), .level(level), .pol(pol),
    .hsync(hsync), .clamp_pin(clamp_pin), .adc_red(adc_red), .adc_green(adc_green),
    .adc_blue(adc_blue));

  // 125 MHz pixel clock
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Hang guard, well above the longest rate test
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      miscompares++;
      results();
    end
  end

  // ====================
  // Tasks
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : chk

  // Inputs always move just after the edge
  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_we = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    tick();
    reg_we = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_re = 1'b1;
    reg_addr = a;
    tick();
    reg_re = 1'b0;
    d = reg_rdata;
  endtask : rd

  // Start of the next sync pulse
  task automatic line_start();
    while (hsync) tick();
    while (!hsync) tick();
  endtask : line_start

  // Clamp delay and length after the next trailing edge
  task automatic meas(output int dly, output int len);
    dly = 0;
    len = 0;
    line_start();
    while (hsync) tick();
    for (int n = 0; n < 120; n++)
    begin
      tick();
      if (clamp_out && len == 0) dly = n;
      if (clamp_out) len++;
    end
  endtask : meas

  task automatic results();
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : results

  // ====================
  // Main sequence
  initial
  begin
    logic [7:0] d;
    int         dl, ln;
    logic [8:0] r0, g0, b0;
    nrst = 1'b0;
    reg_we = 1'b0;
    reg_re = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    level = 8'h01;
    pol = 1'b1;
    repeat (2) @(posedge clk);
    #1 nrst = 1'b1;
    // Reset value, write, read back; unmapped byte last reads zero
    foreach (rows[i])
    begin
      rd(rows[i][31:24], d);
      chk(16'(d), 16'(rows[i][23:16]));
      wr(rows[i][31:24], rows[i][15:8]);
      rd(rows[i][31:24], d);
      chk(16'(d), 16'(rows[i][7:0]));
    end
    chk(16'(gain_red), 16'h007F);
    chk(16'(gain_green), 16'h0035);
    chk(16'(gain_blue), 16'h0040);
    chk(16'(clamp_mid), 16'h0005);
    chk(16'(offset_red), 16'h01C1);
    chk(16'(offset_green), 16'h003F);
    // Internal clamp; rise expected placement plus one after the edge
    foreach (pd[i])
    begin
      wr(OFS_CLAMP_PLACEMENT, pd[i][15:8]);
      wr(OFS_CLAMP_DURATION, pd[i][7:0]);
      meas(dl, ln);
      chk(16'(ln), 16'(pd[i][7:0]));
      // Trailing edge seen one cycle late, clamp output registered
      if (pd[i][7:0] != 8'h00) chk(16'(dl), 16'(pd[i][15:8]) + 16'h0001);
    end
    // External strobe, active high then active low
    for (int p = 1; p >= 0; p--)
    begin
      pol = p[0];
      wr(OFS_CLAMP_CONTROL, {1'b0, p[0], 6'h10});
      meas(dl, ln);
      chk(16'(ln), 16'h000A);
    end
    wr(OFS_CLAMP_CONTROL, 8'h00);
    // Last clamp row left a zero duration, which would open no window
    wr(OFS_CLAMP_DURATION, 8'h28);
    // enable first, then targets 4, -2 and 40 against a black level of 1
    wr(OFS_AUTO_OFFSET_CTRL, 8'h20);
    // targets nonzero, within the ground range
    foreach (tg[i]) wr(tg[i][15:8], tg[i][7:0]);
    // ground clamps; code 110 comes up at k = 2
    for (int k = 0; k < 4; k++)
    begin
      wr(OFS_AUTO_OFFSET_CTRL, 8'h20 | 8'(k << 3));
      line_start();
      r0 = offset_red;
      g0 = offset_green;
      b0 = offset_blue;
      repeat (ivl[k] * 128) tick();
      r0 = offset_red - r0;
      g0 = offset_green - g0;
      b0 = offset_blue - b0;
      chk(16'(r0), 16'h0001);
      chk(16'(g0), 16'h01FF);
      chk(16'(b0), 16'h0001);
    end
    // One-time mode: re-arm through manual, then one step in four lines
    wr(OFS_AUTO_OFFSET_CTRL, 8'h00);
    wr(OFS_CALIBRATION_HOLD, 8'h10);
    wr(OFS_AUTO_OFFSET_CTRL, 8'h20);
    r0 = offset_red;
    repeat (512) tick();
    r0 = offset_red - r0;
    chk(16'(r0), 16'h0001);
    // Auto off: manual bytes take over again
    wr(OFS_AUTO_OFFSET_CTRL, 8'h00);
    repeat (2) tick();
    chk(16'(offset_red), 16'h0002);
    chk(16'(offset_green), 16'h01FF);
    // Mid-run reset brings back the recommended clamp timing
    nrst = 1'b0;
    repeat (2) tick();
    nrst = 1'b1;
    rd(OFS_CLAMP_PLACEMENT, d);
    chk(16'(d), 16'h0004);
    chk(16'(offset_green), 16'h0000);
    results();
  end
endmodule : cog_clamp_offset_gain_test

// File: verification/cog_source_model.sv
`timescale 1ns/1ps
// ====================
// Picture source: sync, clamp strobe, samples
module cog_source_model
(
  // Clock
  input  wire logic       clk,
  // Black level on the back porch, strobe active level
  input  wire logic [7:0] level,
  input  wire logic       pol,
  // Source outputs
  output logic            hsync,
  output logic            clamp_pin,
  output logic [7:0]      adc_red,
  output logic [7:0]      adc_green,
  output logic [7:0]      adc_blue
);
  logic [6:0] pos_r = 7'h00;  // Pixel within a 128-pixel line

  // Free-running line position
  always_ff @(posedge clk) pos_r <= pos_r + 7'h01;
  // Sync on pixels 0 to 7, so its trailing edge is pixel 8
  assign hsync = pos_r < 7'h08;
  // strobe on 20..29, ending long before video at 100
  assign clamp_pin = ((pos_r >= 7'h14) && (pos_r < 7'h1E)) ~^ pol;
  // Busy picture in active video so it never passes for black
  assign adc_red   = (pos_r >= 7'h64) ? {1'b1, pos_r} : level;
  assign adc_green = (pos_r >= 7'h64) ? {pos_r, 1'b1} : level;
  assign adc_blue  = (pos_r >= 7'h64) ? ~{1'b0, pos_r} : level;
endmodule : cog_source_model
